// ===== psd_defines.svh
`ifndef PSD_DEFINES_SVH
`define PSD_DEFINES_SVH
// Overview of operation
// - A mode input selects whether the shared pin acts as driver enable or doubler power state.
// - In driver-enable mode the shared pin is driven high for states 0 to 3 and low for state 4.
// - In doubler mode the shared pin is driven high for state 4.
// - In doubler mode the shared pin is driven low for state 0.
// - In doubler mode the shared pin is released, undriven, for state 1.
// - In doubler mode the shared pin is driven high for state 2 or state 3.
// - The link alert is shown on an active-low output that goes low while asserted.
// - The thermal alarm is shown on an active-low output that goes low while asserted.

// ----------------------------------------------------------------------
// Power-state codes
// ----------------------------------------------------------------------
`define PSD_STATE_W 3
`define PSD_STATE_0 3'h0
`define PSD_STATE_1 3'h1
`define PSD_STATE_2 3'h2
`define PSD_STATE_3 3'h3
`define PSD_STATE_4 3'h4
`define PSD_STATE_RESET 3'h4

// ----------------------------------------------------------------------
// Mode select and serial frame
// ----------------------------------------------------------------------
`define PSD_MODE_DRIVER 1'b0
`define PSD_MODE_DOUBLER 1'b1
`define PSD_START_BIT 1'b0
`define PSD_BIT_CNT_W 2
`define PSD_LAST_BIT 2'h2
`define PSD_SYNC_IDLE 2'h2
`endif

// ===== psd_pkg.sv
package psd_pkg;
    typedef enum logic {
        PSD_RX_IDLE,
        PSD_RX_SHIFT
    } psd_rx_state_t;

    typedef struct packed {
        logic valid;
        logic [2:0] state;
    } psd_cmd_t;

    typedef struct packed {
        logic level;
        logic oe;
    } psd_pin_t;
endpackage : psd_pkg

// ===== psd_power_state_driver_ctrl.sv
`timescale 1ns/1ns
`include "psd_defines.svh"

module psd_power_state_driver_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Link pins from the processor
    input wire logic link_clock_in,
    input wire logic link_data_io_in,
    // Configuration and status from on-chip logic
    input wire logic shared_pin_mode,
    input wire logic link_alert_req,
    input wire logic thermal_hot,
    // Shared output pin
    output logic shared_pin_out,
    output logic shared_pin_oe,
    // Active-low indications
    output logic link_alert_n,
    output logic thermal_alarm_n,
    // Last accepted power state
    output logic [2:0] power_state
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Both link pins pass the same two-stage chain, one lane each, so the
    // data bit stays aligned with the clock edge that samples it. Reset
    // loads each lane with its idle level: the link clock rests low and
    // the data line rests high, so no false edge or start bit follows the
    // release of reset.
    localparam int SYNC_LANES = 2;
    localparam int LANE_CLK = 0;
    localparam int LANE_DAT = 1;
    localparam logic [SYNC_LANES-1:0] SYNC_IDLE = `PSD_SYNC_IDLE;

    wire [SYNC_LANES-1:0] sync_pin;
    wire [SYNC_LANES-1:0] sync_out;
    logic lclk_s3;
    logic next_lclk_s3;
    logic ldat_s2;
    logic lclk_rise;

    assign sync_pin[LANE_CLK] = link_clock_in;
    assign sync_pin[LANE_DAT] = link_data_io_in;

    genvar lane;
    generate
        for (lane = 0; lane < SYNC_LANES; lane = lane + 1) begin : g_sync
            logic s1;
            logic s2;
            logic next_s1;
            logic next_s2;

            always_comb begin
                next_s1 = sync_pin[lane];
                next_s2 = s1;
            end

            always_ff @(posedge clk) begin
                if (srst) begin
                    s1 <= SYNC_IDLE[lane];
                    s2 <= SYNC_IDLE[lane];
                end else begin
                    s1 <= next_s1;
                    s2 <= next_s2;
                end
            end

            assign sync_out[lane] = s2;
        end
    endgenerate

    // The third stage on the clock lane reads only the second stage, so
    // the edge detector never sees a level that may still be settling.
    always_comb begin
        next_lclk_s3 = sync_out[LANE_CLK];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            lclk_s3 <= SYNC_IDLE[LANE_CLK];
        end else begin
            lclk_s3 <= next_lclk_s3;
        end
    end

    assign ldat_s2 = sync_out[LANE_DAT];
    assign lclk_rise = sync_out[LANE_CLK] & ~lclk_s3;

    // ------------------------------------------------------------------
    // Command receiver
    // ------------------------------------------------------------------
    // A frame is a low start bit followed by three state bits, most
    // significant first, each taken on a rising link clock edge.
    // There is no abort: a frame cut short leaves the receiver in shift,
    // and the rising edges of the next frame complete it, so the link
    // must always send whole frames.
    psd_pkg::psd_rx_state_t rx_state;
    psd_pkg::psd_rx_state_t next_rx_state;
    logic [`PSD_BIT_CNT_W-1:0] bit_cnt;
    logic [`PSD_BIT_CNT_W-1:0] next_bit_cnt;
    logic [2:0] shift;
    logic [2:0] next_shift;
    psd_pkg::psd_cmd_t cmd;
    psd_pkg::psd_cmd_t next_cmd;

    always_comb begin
        next_rx_state = rx_state;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_cmd.valid = 1'b0;
        next_cmd.state = cmd.state;
        case (rx_state)
            psd_pkg::PSD_RX_IDLE: begin
                if (lclk_rise && ldat_s2 == `PSD_START_BIT) begin
                    next_rx_state = psd_pkg::PSD_RX_SHIFT;
                    next_bit_cnt = '0;
                end
            end
            psd_pkg::PSD_RX_SHIFT: begin
                if (lclk_rise) begin
                    next_shift = {shift[1:0], ldat_s2};
                    next_bit_cnt = bit_cnt + 2'h1;
                    if (bit_cnt == `PSD_LAST_BIT) begin
                        next_cmd.valid = 1'b1;
                        next_cmd.state = {shift[1:0], ldat_s2};
                        next_rx_state = psd_pkg::PSD_RX_IDLE;
                    end
                end
            end
            default: begin
                next_rx_state = psd_pkg::PSD_RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_state <= psd_pkg::PSD_RX_IDLE;
            bit_cnt <= '0;
            shift <= '0;
            cmd <= '0;
        end else begin
            rx_state <= next_rx_state;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            cmd <= next_cmd;
        end
    end

    // ------------------------------------------------------------------
    // Held power state
    // ------------------------------------------------------------------
    // Codes above state 4 are ignored so a corrupt frame cannot move
    // the pin to an undefined level.
    // The trade-off is that a refused code is dropped silently: the
    // processor gets no sign that it was not taken, and the pin keeps
    // the state of the last accepted command.
    logic [2:0] next_power_state;

    always_comb begin
        next_power_state = power_state;
        if (cmd.valid && cmd.state <= `PSD_STATE_4) begin
            next_power_state = cmd.state;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            power_state <= `PSD_STATE_RESET;
        end else begin
            power_state <= next_power_state;
        end
    end

    // ------------------------------------------------------------------
    // Shared pin decode and indications
    // ------------------------------------------------------------------
    // The mode input is applied to the held state at the next clock edge, so a mode
    // change needs no new command.
    // The pin is released during reset, so nothing downstream is driven
    // before the first decode of the reset state.
    psd_pkg::psd_pin_t pin;
    psd_pkg::psd_pin_t next_pin;
    logic next_alert_n;
    logic next_thermal_n;

    always_comb begin
        next_pin.level = 1'b0;
        next_pin.oe = 1'b1;
        if (shared_pin_mode == `PSD_MODE_DRIVER) begin
            next_pin.level = (next_power_state != `PSD_STATE_4);
        end else begin
            case (next_power_state)
                `PSD_STATE_0: next_pin.level = 1'b0;
                `PSD_STATE_1: next_pin.oe = 1'b0;
                `PSD_STATE_2, `PSD_STATE_3: next_pin.level = 1'b1;
                `PSD_STATE_4: next_pin.level = 1'b1;
                default: next_pin.level = 1'b0;
            endcase
        end
        next_alert_n = ~link_alert_req;
        next_thermal_n = ~thermal_hot;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pin <= '0;
            link_alert_n <= 1'b1;
            thermal_alarm_n <= 1'b1;
        end else begin
            pin <= next_pin;
            link_alert_n <= next_alert_n;
            thermal_alarm_n <= next_thermal_n;
        end
    end

    assign shared_pin_out = pin.level;
    assign shared_pin_oe = pin.oe;

endmodule : psd_power_state_driver_ctrl

// ===== psd_ctrl_props.sv
`timescale 1ns/1ns
module psd_ctrl_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Watched pins
    input wire logic shared_pin_mode,
    input wire logic link_alert_req,
    input wire logic thermal_hot,
    input wire logic shared_pin_out,
    input wire logic shared_pin_oe,
    input wire logic link_alert_n,
    input wire logic thermal_alarm_n,
    input wire logic [2:0] power_state
);
    // The pin follows the mode of the edge before, so the release edge is skipped.
    logic pv;
    logic dv;
    wire bv = pv && !dv;
    wire [1:0] pin = {shared_pin_oe, shared_pin_out};
    wire [2:0] ps = power_state;
    always_ff @(posedge clk) begin
        pv <= !srst;
        dv <= !srst && !shared_pin_mode;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    property p_on; dv && ps != 3'h4 |-> pin == 2'h3; endproperty
    a_on: assert property (p_on) else $error("enable low");
    property p_off; dv && ps == 3'h4 |-> pin == 2'h2; endproperty
    a_off: assert property (p_off) else $error("enable high");
    property p_d4; bv && ps == 3'h4 |-> pin == 2'h3; endproperty
    a_d4: assert property (p_d4) else $error("doubler not high");
    property p_d0; bv && ps == 3'h0 |-> pin == 2'h2; endproperty
    a_d0: assert property (p_d0) else $error("doubler not low");
    property p_d1; bv && ps == 3'h1 |-> !pin[1]; endproperty
    a_d1: assert property (p_d1) else $error("doubler driven");
    property p_d23; bv && ps[2:1] == 2'h1 |-> pin == 2'h3; endproperty
    a_d23: assert property (p_d23) else $error("doubler not high");
    property p_al; pv |-> link_alert_n == !$past(link_alert_req); endproperty
    a_al: assert property (p_al) else $error("alert wrong");
    property p_hot; pv |-> thermal_alarm_n == !$past(thermal_hot); endproperty
    a_hot: assert property (p_hot) else $error("alarm wrong");
    cover property (bv && ps == 3'h1);
    cover property (dv && ps == 3'h4);
    cover property (!link_alert_n && !thermal_alarm_n);
endmodule : psd_ctrl_chk

// ===== psd_link_host.sv
`timescale 1ns/1ns
module psd_link_host (
    // Link pins
    output logic link_clock_in,
    output logic link_data_io_in
);
    // The clock rests low between frames and the data line returns to its pull-up.
    initial begin
        link_clock_in = 1'b0;
        link_data_io_in = 1'b1;
    end
    task automatic send(input logic [2:0] code);
        logic [3:0] f;
        f = {1'b0, code};
        #7;
        for (int i = 3; i >= 0; i--) begin
            link_data_io_in = f[i];
            #80 link_clock_in = 1'b1;
            #80 link_clock_in = 1'b0;
        end
        link_data_io_in = 1'b1;
    endtask : send
endmodule : psd_link_host

// ===== psd_power_state_driver_ctrl_tb_top.sv
`timescale 1ns/1ns
module psd_power_state_driver_ctrl_tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic mode = 1'b0;
    logic alr = 1'b0;
    logic hot = 1'b0;
    logic lck;
    logic ldat;
    logic aln;
    logic thn;
    logic p_out;
    logic p_oe;
    logic [2:0] ps;
    logic [2:0] last = 3'h4;
    logic [2:0] cur = 3'h4;
    logic [2:0] c;
    logic [2:0] e;
    logic [2:0] q[$];
    int err_count = 0;
    int tests_run = 0;
    always #10 clk = ~clk;
    psd_link_host psd_link_host_inst (.link_clock_in(lck), .link_data_io_in(ldat));
    psd_power_state_driver_ctrl psd_power_state_driver_ctrl_inst (.clk(clk), .srst(srst),
        .link_clock_in(lck), .link_data_io_in(ldat), .shared_pin_mode(mode),
        .link_alert_req(alr), .thermal_hot(hot), .shared_pin_out(p_out), .shared_pin_oe(p_oe),
        .link_alert_n(aln), .thermal_alarm_n(thn), .power_state(ps));
    task automatic check(input logic [2:0] s, input logic [2:0] x);
        tests_run++;
        if (s !== x) begin
            err_count++;
            $display("mismatch %0t: %h vs %h", $time, s, x);
        end
    endtask : check
    task automatic results;
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    always @(negedge clk) begin
        if (!srst && ps !== last) begin
            check(ps, q.size() > 0 ? q.pop_front() : 3'hx);
        end
        last = ps;
    end
    initial begin
        void'($urandom(73));
        repeat (2) @(negedge clk);
        srst = 1'b0;
        check(ps, 3'h4);
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            if (i == 20) begin
                srst = 1'b1;
                repeat (2) @(negedge clk);
                srst = 1'b0;
                cur = 3'h4;
                check(ps, 3'h4);
            end
            mode = i < 16 ? i[3] : 1'($urandom);
            c = i < 16 ? i[2:0] : 3'($urandom);
            alr = 1'($urandom);
            hot = 1'($urandom);
            if (c <= 3'h4 && c != cur) begin
                q.push_back(c);
                cur = c;
            end
            psd_link_host_inst.send(c);
            if (i % 3 != 0) begin
                repeat (10) @(negedge clk);
                e = cur == 3'h4 ? 3'h2 : 3'h3;
                if (mode)
                    e = cur == 3'h0 ? 3'h2 : cur == 3'h1 ? 3'h0 : 3'h3;
                check({1'b0, p_oe, p_oe & p_out}, e);
                check({1'b0, aln, thn}, {1'b0, ~alr, ~hot});
            end
        end
        results();
    end
    initial begin
        #100000;
        err_count++;
        results();
    end
endmodule : psd_power_state_driver_ctrl_tb_top
bind psd_power_state_driver_ctrl psd_ctrl_chk psd_ctrl_chk_inst (.clk, .srst,
    .shared_pin_mode, .link_alert_req, .thermal_hot, .shared_pin_out, .shared_pin_oe,
    .link_alert_n, .thermal_alarm_n, .power_state);
